// File: rsm_pkg.sv
// package: constants and types of the radio serial message codec
package rsm_pkg;

	// =========================================================
	// bus register map, byte addresses
	localparam logic [7:0] RSM_OFS_CTRL   = 8'h00;
	localparam logic [7:0] RSM_OFS_NAVDEV = 8'h04;
	localparam logic [7:0] RSM_OFS_COURSE = 8'h08;
	localparam logic [7:0] RSM_OFS_RADIAL = 8'h0C;
	localparam logic [7:0] RSM_OFS_FREQ   = 8'h10;
	localparam logic [7:0] RSM_OFS_CSTAT  = 8'h14;
	localparam logic [7:0] RSM_OFS_AUDIO  = 8'h18;
	localparam logic [7:0] RSM_OFS_NAVVER = 8'h1C;
	localparam logic [7:0] RSM_OFS_COMVER = 8'h20;
	localparam logic [7:0] RSM_OFS_NAVST  = 8'h24;
	localparam logic [7:0] RSM_OFS_REQ    = 8'h28;
	localparam logic [7:0] RSM_OFS_STATUS = 8'h2C;

	// =========================================================
	// field positions
	localparam int RSM_F_PER = 0, RSM_F_SUM = 1, RSM_F_ENG = 2,
		RSM_F_FN = 8, RSM_F_LAT = 0, RSM_F_GS = 8, RSM_F_FLG = 16,
		RSM_F_TENTH = 16, RSM_F_VOL = 0, RSM_F_SQ = 8, RSM_F_GAIN = 16,
		RSM_F_SIDE = 24, RSM_F_SQT = 2, RSM_F_BUSY = 15,
		RSM_F_ERR = 16;

	// =========================================================
	// reset values
	localparam logic [31:0] RSM_CTRL_RST  = 32'h0000_4E01;
	localparam logic [31:0] RSM_FREQ_RST  = 32'h0076_0076;
	localparam logic [31:0] RSM_VER_RST   = 32'h3031_3030;
	localparam logic [31:0] RSM_NAVST_RST = 32'h3030_3030;
	localparam logic [4:0]  RSM_LVL_RST   = 5'h0A;
	localparam logic [10:0] RSM_PEND_RST  = 11'h001;

	// =========================================================
	// characters and value limits
	localparam logic [31:0] RSM_SENTENCE_PREFIX = 32'h504D_5252;
	localparam logic [7:0] RSM_CH_DOLLAR = 8'h24, RSM_CH_CLASS = 8'h56,
		RSM_CH_CR = 8'h0D, RSM_CH_LF = 8'h0A, RSM_CH_ZERO = 8'h30,
		RSM_CH_REL = 8'h52, RSM_CH_ENG = 8'h45, RSM_CH_INV = 8'h49,
		RSM_ENC_OFS = 8'h30;
	localparam logic [31:0] RSM_CH_TSTAT = 32'h5254_5346;
	localparam logic [4:0] RSM_LVL_MIN = 5'h01, RSM_LVL_MAX = 5'h14;
	localparam logic signed [7:0] RSM_DEV_MAX = 8'sh64;
	localparam logic [7:0] RSM_MHZ_LO = 8'h76, RSM_MHZ_HI = 8'h88,
		RSM_MHZ_ALT = 8'hA2, RSM_KIDX_MAX = 8'h27;
	localparam logic [8:0] RSM_DEG_MAX = 9'h167;

	// =========================================================
	// sentence kinds, identifiers and payload lengths
	typedef enum logic [3:0] {
		S_READY = 4'h0, S_NAV = 4'h1, S_COURSE = 4'h2, S_RADIAL = 4'h3,
		S_ERR = 4'h4, S_RXSTAT = 4'h5, S_NAVVER = 4'h6, S_COMSTAT = 4'h7,
		S_COMVER = 4'h8, S_VOL = 4'h9, S_MIC = 4'hA
	} rsm_sent_t;
	localparam int RSM_NUM_SENT = 11;
	localparam logic [15:0] RSM_ID [RSM_NUM_SENT] = '{16'h3230, 16'h3231,
		16'h3232, 16'h3233, 16'h3237, 16'h3238, 16'h3330, 16'h3335,
		16'h3336, 16'h3731, 16'h3732};
	localparam logic [2:0] RSM_PLEN [RSM_NUM_SENT] = '{3'h0, 3'h6, 3'h3,
		3'h5, 3'h1, 3'h5, 3'h5, 3'h6, 3'h4, 3'h2, 3'h2};
	localparam logic [15:0] RSM_ID_REQ = 16'h3234;
	localparam logic [4:0] RSM_LEN_MIN = 5'h09, RSM_LEN_MIC = 5'h0B;

	typedef enum logic [2:0] {
		TX_IDLE = 3'h0, TX_BODY = 3'h1, TX_SUM_HI = 3'h2,
		TX_SUM_LO = 3'h3, TX_CR = 3'h4, TX_LF = 3'h5
	} rsm_tx_st_t;

	// =========================================================
	// timing: periodic sentences every 100 ms at a 4 ns clock
	localparam longint RSM_CLK_NS  = 4;
	localparam longint RSM_TICK_NS = 100000000;
	localparam int RSM_TICK_CYCLES = int'(RSM_TICK_NS / RSM_CLK_NS);

endpackage

// File: rsm_codec.sv
`timescale 1ns/1ns
// module: radio serial message codec with bus slave, rx and tx framing
// =============================================================
module rsm_codec
	import rsm_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = RSM_TICK_CYCLES
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	output logic             tx_valid,
	output logic      [7:0]  tx_data,
	input  wire logic        tx_ready
);

	// =========================================================
	// helpers
	function automatic logic [7:0] csum_add(input logic m,
		input logic [7:0] a, input logic [7:0] c);
		return m ? 8'(a + c) : (a ^ c);
	endfunction

	function automatic logic [15:0] enc(input logic [7:0] b);
		return {4'h3, b[7:4], 4'h3, b[3:0]};
	endfunction

	function automatic logic [7:0] digit(input logic [8:0] v,
		input logic [8:0] d);
		logic [8:0] q;
		q = (v / d) % 9'h00A;
		return RSM_CH_ZERO + {4'h0, q[3:0]};
	endfunction

	function automatic logic lvl_ok(input logic [4:0] v,
		input logic [4:0] lo);
		return (v >= lo) && (v <= RSM_LVL_MAX);
	endfunction

	function automatic logic freq_ok(input logic [7:0] m,
		input logic [7:0] k);
		return ((m >= RSM_MHZ_LO && m <= RSM_MHZ_HI) || m == RSM_MHZ_ALT)
			&& (k <= RSM_KIDX_MAX);
	endfunction

	function automatic logic signed [7:0] clamp(input logic signed [7:0] v);
		if (v > RSM_DEV_MAX)
			return RSM_DEV_MAX;
		if (v < -RSM_DEV_MAX)
			return -RSM_DEV_MAX;
		return v;
	endfunction

	// =========================================================
	// state
	logic [31:0] ctrl_q, freq_q, nav_ver_q, com_ver_q, nav_st_q, nav_st_p_q;
	logic [23:0] nav_dev_q;
	logic [8:0]  course_q, radial_q;
	logic [3:0]  tenth_q;
	logic [2:0]  cstat_q;
	logic [4:0]  vol_q, sq_q, gain_q, side_q;
	logic [19:0] aud_p_q;
	logic [1:0]  err_code_q;
	logic [10:0] pend_q, pend_set, pend_clr;
	logic        wr_q, rd_q, started_q, tick_q;
	logic [7:0]  wr_addr_q, rd_addr_q;
	logic [31:0] cnt_q;
	logic        bus_err_v;

	// =========================================================
	// AHB-Lite slave: writes are zero wait, reads add one wait state
	// so a read right behind a write sees the written value
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q      <= 1'b0;
			rd_q      <= 1'b0;
			wr_addr_q <= 8'h00;
			rd_addr_q <= 8'h00;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h0000_0000;
		end else begin
			wr_q <= 1'b0;
			if (rd_q) begin
				rd_q      <= 1'b0;
				hreadyout <= 1'b1;
				hrdata    <= reg_read(rd_addr_q);
			end else if (hsel && htrans[1] && hready) begin
				wr_q      <= hwrite && hsize == 3'h2;
				wr_addr_q <= haddr[7:0];
				rd_q      <= !hwrite;
				rd_addr_q <= haddr[7:0];
				hreadyout <= hwrite;
			end
		end
	end

	function automatic logic [31:0] reg_read(input logic [7:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		unique case (a)
			RSM_OFS_CTRL:   r = ctrl_q;
			RSM_OFS_NAVDEV: r = {8'h00, nav_dev_q};
			RSM_OFS_COURSE: r = {23'h0, course_q};
			RSM_OFS_RADIAL: r = {12'h0, tenth_q, 7'h0, radial_q};
			RSM_OFS_FREQ:   r = freq_q;
			RSM_OFS_CSTAT:  r = {29'h0, cstat_q};
			RSM_OFS_AUDIO:  r = {3'h0, side_q, 3'h0, gain_q,
				3'h0, sq_q, 3'h0, vol_q};
			RSM_OFS_NAVVER: r = nav_ver_q;
			RSM_OFS_COMVER: r = com_ver_q;
			RSM_OFS_NAVST:  r = nav_st_q;
			RSM_OFS_STATUS: r = {14'h0, err_code_q, tx_valid, 4'h0, pend_q};
			default:        r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	// =========================================================
	// receive framing; pins are taken as synchronous, one char a cycle
	logic       rx_on_q, rx_hdr_q;
	logic [4:0] rx_pos_q;
	logic [7:0] rx_acc_q, rx_c1_q, rx_c2_q, rx_p0_q, rx_p1_q;
	logic [15:0] rx_id_q;
	logic       rx_end, rx_err_v, rx_req_v, rx_mic_v, rx_cs_bad;
	logic [1:0] rx_err_c;
	logic [3:0] rx_req_t;
	logic [7:0] rx_body;
	logic [4:0] rx_gain, rx_side;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_on_q  <= 1'b0;
			rx_hdr_q <= 1'b0;
			rx_pos_q <= 5'h00;
			rx_acc_q <= 8'h00;
			rx_c1_q  <= 8'h00;
			rx_c2_q  <= 8'h00;
			rx_p0_q  <= 8'h00;
			rx_p1_q  <= 8'h00;
			rx_id_q  <= 16'h0000;
		end else if (rx_valid && rx_data == RSM_CH_DOLLAR) begin
			rx_on_q  <= 1'b1;
			rx_hdr_q <= 1'b1;
			rx_pos_q <= 5'h00;
			rx_acc_q <= 8'h00;
		end else if (rx_end) begin
			rx_on_q <= 1'b0;
		end else if (rx_valid && rx_on_q && rx_data != RSM_CH_LF) begin
			rx_acc_q <= csum_add(ctrl_q[RSM_F_SUM], rx_acc_q, rx_data);
			rx_c1_q  <= rx_data;
			rx_c2_q  <= rx_c1_q;
			if (rx_pos_q != 5'h1F)
				rx_pos_q <= rx_pos_q + 5'h01;
			// prefix then class; any mismatch marks the sentence unknown
			if (rx_pos_q < 5'h04 && rx_data !=
				RSM_SENTENCE_PREFIX[8*(3-int'(rx_pos_q)) +: 8])
				rx_hdr_q <= 1'b0;
			if (rx_pos_q == 5'h04 && rx_data != RSM_CH_CLASS)
				rx_hdr_q <= 1'b0;
			if (rx_pos_q == 5'h05)
				rx_id_q[15:8] <= rx_data;
			if (rx_pos_q == 5'h06)
				rx_id_q[7:0] <= rx_data;
			if (rx_pos_q == 5'h07)
				rx_p0_q <= rx_data;
			if (rx_pos_q == 5'h08)
				rx_p1_q <= rx_data;
		end
	end

	// sentence check at CR: the last two chars are the checksum
	always_comb begin
		rx_end   = rx_valid && rx_on_q && rx_data == RSM_CH_CR;
		rx_body  = ctrl_q[RSM_F_SUM] ? 8'(rx_acc_q - rx_c1_q - rx_c2_q)
			: (rx_acc_q ^ rx_c1_q ^ rx_c2_q);
		rx_cs_bad = rx_body != {rx_c2_q[3:0], rx_c1_q[3:0]};
		rx_gain  = 5'(rx_p0_q - RSM_ENC_OFS);
		rx_side  = 5'(rx_p1_q - RSM_ENC_OFS);
		rx_err_v = 1'b0;
		rx_err_c = 2'h1;
		rx_req_v = 1'b0;
		rx_req_t = 4'h0;
		rx_mic_v = 1'b0;
		for (int i = 0; i < RSM_NUM_SENT; i++)
			if ({rx_p0_q, rx_p1_q} == RSM_ID[i])
				rx_req_t = 4'(i);
		if (rx_end) begin
			if (!rx_hdr_q || rx_pos_q < RSM_LEN_MIN) begin
				rx_err_v = 1'b1;
			end else if (rx_cs_bad) begin
				rx_err_v = 1'b1;
				rx_err_c = 2'h0;
			end else if (rx_id_q == RSM_ID[S_MIC]) begin
				// gain and sidetone must both be 1..20, each char a level+30h
				// whole-byte bounds, so the chars for levels 16 to 20 pass
				rx_mic_v = rx_pos_q == RSM_LEN_MIC
					&& rx_p0_q >= RSM_ENC_OFS && rx_p1_q >= RSM_ENC_OFS
					&& rx_p0_q <= RSM_ENC_OFS + {3'h0, RSM_LVL_MAX}
					&& rx_p1_q <= RSM_ENC_OFS + {3'h0, RSM_LVL_MAX}
					&& lvl_ok(rx_gain, RSM_LVL_MIN)
					&& lvl_ok(rx_side, RSM_LVL_MIN);
				rx_err_v = !rx_mic_v;
				rx_err_c = 2'h2;
			end else if (rx_id_q == RSM_ID_REQ) begin
				rx_req_v = rx_pos_q >= RSM_LEN_MIC
					&& {rx_p0_q, rx_p1_q} == RSM_ID[rx_req_t];
				rx_err_v = !rx_req_v;
				rx_err_c = 2'h2;
			end else begin
				rx_err_v = 1'b1;
			end
		end
	end

	// =========================================================
	// software registers; rx mic command shares the level fields
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q    <= RSM_CTRL_RST;
			nav_dev_q <= 24'h000000;
			course_q  <= 9'h000;
			radial_q  <= 9'h000;
			tenth_q   <= 4'h0;
			freq_q    <= RSM_FREQ_RST;
			cstat_q   <= 3'h0;
			vol_q     <= RSM_LVL_RST;
			sq_q      <= RSM_LVL_RST;
			gain_q    <= RSM_LVL_RST;
			side_q    <= RSM_LVL_RST;
			nav_ver_q <= RSM_VER_RST;
			com_ver_q <= RSM_VER_RST;
			nav_st_q  <= RSM_NAVST_RST;
		end else if (wr_q) begin
			unique case (wr_addr_q)
				RSM_OFS_CTRL:   ctrl_q <= hwdata;
				RSM_OFS_NAVDEV: nav_dev_q <= hwdata[23:0];
				RSM_OFS_COURSE: course_q <= hwdata[8:0];
				RSM_OFS_RADIAL: begin
					radial_q <= hwdata[8:0];
					tenth_q  <= hwdata[RSM_F_TENTH +: 4];
				end
				RSM_OFS_FREQ: begin
					if (freq_ok(hwdata[7:0], hwdata[15:8]) &&
						freq_ok(hwdata[23:16], hwdata[31:24]))
						freq_q <= hwdata;
				end
				RSM_OFS_CSTAT:  cstat_q <= hwdata[2:0];
				RSM_OFS_AUDIO: begin
					if (lvl_ok(hwdata[RSM_F_VOL +: 5], 5'h00)
						&& lvl_ok(hwdata[RSM_F_SQ +: 5], 5'h00)) begin
						vol_q <= hwdata[RSM_F_VOL +: 5];
						sq_q  <= hwdata[RSM_F_SQ +: 5];
					end
					if (lvl_ok(hwdata[RSM_F_GAIN +: 5], RSM_LVL_MIN)
						&& lvl_ok(hwdata[RSM_F_SIDE +: 5], RSM_LVL_MIN)) begin
						gain_q <= hwdata[RSM_F_GAIN +: 5];
						side_q <= hwdata[RSM_F_SIDE +: 5];
					end
				end
				RSM_OFS_NAVVER: nav_ver_q <= hwdata;
				RSM_OFS_COMVER: com_ver_q <= hwdata;
				RSM_OFS_NAVST:  nav_st_q <= hwdata;
				default: ;
			endcase
		end else if (rx_mic_v) begin
			gain_q <= rx_gain;
			side_q <= rx_side;
		end
	end

	// frequency validity on write; a rejected pair keeps the old one
	assign bus_err_v = wr_q && wr_addr_q == RSM_OFS_FREQ &&
		!(freq_ok(hwdata[7:0], hwdata[15:8]) &&
		freq_ok(hwdata[23:16], hwdata[31:24]));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			err_code_q <= 2'h0;
		else if (rx_err_v)
			err_code_q <= rx_err_c;
		else if (bus_err_v)
			err_code_q <= 2'h2;
	end

	// =========================================================
	// 10 Hz tick and change detectors (one cycle behind the change)
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q      <= 32'h0000_0000;
			tick_q     <= 1'b0;
			aud_p_q    <= {4{RSM_LVL_RST}};
			nav_st_p_q <= RSM_NAVST_RST;
		end else begin
			tick_q     <= cnt_q == 32'(TICK_CYCLES - 1);
			cnt_q      <= (cnt_q == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000
				: cnt_q + 32'h0000_0001;
			aud_p_q    <= {vol_q, sq_q, gain_q, side_q};
			nav_st_p_q <= nav_st_q;
		end
	end

	// =========================================================
	// pending queue: a new request wins over the clear of the start
	always_comb begin
		pend_set = 11'h000;
		if (tick_q && ctrl_q[RSM_F_PER]) begin
			pend_set[S_NAV]    = 1'b1;
			pend_set[S_COURSE] = 1'b1;
			pend_set[S_RADIAL] = 1'b1;
		end
		if (wr_q && wr_addr_q == RSM_OFS_REQ)
			pend_set = pend_set | hwdata[10:0];
		if (rx_req_v)
			pend_set[rx_req_t] = 1'b1;
		if (rx_err_v || bus_err_v)
			pend_set[S_ERR] = 1'b1;
		if (aud_p_q[19:10] != {vol_q, sq_q})
			pend_set[S_VOL] = 1'b1;
		if (aud_p_q[9:0] != {gain_q, side_q})
			pend_set[S_MIC] = 1'b1;
		if (nav_st_p_q != nav_st_q)
			pend_set[S_RXSTAT] = 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pend_q <= RSM_PEND_RST;
		else
			pend_q <= (pend_q & ~pend_clr) | pend_set;
	end

	// =========================================================
	// payload of each sentence kind, chars from the top byte down
	function automatic logic [47:0] pay_vec(input rsm_sent_t t);
		logic [7:0] fl;
		logic [8:0] c, r;
		fl = nav_dev_q[RSM_F_FLG +: 8];
		if ((fl[3] && fl[2]) || !fl[7])
			fl[3:2] = 2'b00;
		c = (course_q > RSM_DEG_MAX) ? RSM_DEG_MAX : course_q;
		r = (radial_q > RSM_DEG_MAX) ? RSM_DEG_MAX : radial_q;
		unique case (t)
			S_NAV: return {enc(clamp(nav_dev_q[RSM_F_LAT +: 8])),
				enc(clamp(nav_dev_q[RSM_F_GS +: 8])), enc(fl)};
			S_COURSE: return {digit(c, 9'h064), digit(c, 9'h00A),
				digit(c, 9'h001), 24'h0};
			S_RADIAL: return {nav_dev_q[RSM_F_FLG + 1] ? RSM_CH_INV
				: RSM_CH_CLASS, digit(r, 9'h064), digit(r, 9'h00A),
				digit(r, 9'h001), RSM_CH_ZERO + {4'h0, tenth_q}, 8'h0};
			S_ERR: return {RSM_CH_ZERO + {6'h0, err_code_q}, 40'h0};
			S_RXSTAT: return {nav_st_q, ctrl_q[RSM_F_FN +: 8], 8'h0};
			S_NAVVER: return {nav_ver_q, ctrl_q[RSM_F_ENG] ? RSM_CH_ENG
				: RSM_CH_REL, 8'h0};
			S_COMSTAT: return {8'(freq_q[7:0] - RSM_ENC_OFS),
				8'(freq_q[15:8] + RSM_ENC_OFS),
				8'(freq_q[23:16] - RSM_ENC_OFS),
				8'(freq_q[31:24] + RSM_ENC_OFS),
				RSM_CH_TSTAT[8*(3-int'(cstat_q[1:0])) +: 8],
				RSM_CH_ZERO + {7'h0, cstat_q[RSM_F_SQT]}};
			S_COMVER: return {com_ver_q, 16'h0};
			S_VOL: return {RSM_ENC_OFS + {3'h0, vol_q},
				RSM_ENC_OFS + {3'h0, sq_q}, 32'h0};
			S_MIC: return {RSM_ENC_OFS + {3'h0, gain_q},
				RSM_ENC_OFS + {3'h0, side_q}, 32'h0};
			default: return 48'h0;
		endcase
	endfunction

	// =========================================================
	// transmitter; tx_data and tx_valid stand until tx_ready
	rsm_tx_st_t tx_st_q;
	rsm_sent_t  tx_type_q, pick;
	logic [3:0] tx_pos_q, tx_last;
	logic [7:0] tx_acc_q;
	logic [47:0] tx_pay_q;
	logic       tx_adv, tx_start;

	always_comb begin
		pick = S_READY;
		for (int i = RSM_NUM_SENT - 1; i >= 0; i--)
			if (pend_q[i])
				pick = rsm_sent_t'(i);
		tx_adv   = !tx_valid || tx_ready;
		tx_start = tx_adv && tx_st_q == TX_IDLE && |pend_q;
		pend_clr = tx_start ? 11'(11'h001 << pick) : 11'h000;
		tx_last  = 4'(4'h7 + {1'b0, RSM_PLEN[tx_type_q]});
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_st_q   <= TX_IDLE;
			tx_type_q <= S_READY;
			tx_pos_q  <= 4'h0;
			tx_acc_q  <= 8'h00;
			tx_pay_q  <= 48'h0;
			tx_valid  <= 1'b0;
			tx_data   <= 8'h00;
		end else if (tx_adv) begin
			unique case (tx_st_q)
				TX_IDLE: begin
					tx_valid <= tx_start;
					if (tx_start) begin
						tx_type_q <= pick;
						tx_pay_q  <= pay_vec(pick);
						tx_data   <= RSM_CH_DOLLAR;
						tx_pos_q  <= 4'h1;
						tx_acc_q  <= 8'h00;
						tx_st_q   <= TX_BODY;
					end
				end
				TX_BODY: begin
					// prefix, class, identifier, then payload
					if (tx_pos_q < 4'h5) begin
						tx_data <= RSM_SENTENCE_PREFIX[8*(4-int'(tx_pos_q)) +: 8];
						tx_acc_q <= csum_add(ctrl_q[RSM_F_SUM], tx_acc_q,
							RSM_SENTENCE_PREFIX[8*(4-int'(tx_pos_q)) +: 8]);
					end else if (tx_pos_q == 4'h5) begin
						tx_data  <= RSM_CH_CLASS;
						tx_acc_q <= csum_add(ctrl_q[RSM_F_SUM], tx_acc_q,
							RSM_CH_CLASS);
					end else if (tx_pos_q < 4'h8) begin
						tx_data <= RSM_ID[tx_type_q][8*(7-int'(tx_pos_q)) +: 8];
						tx_acc_q <= csum_add(ctrl_q[RSM_F_SUM], tx_acc_q,
							RSM_ID[tx_type_q][8*(7-int'(tx_pos_q)) +: 8]);
					end else begin
						tx_data  <= tx_pay_q[47:40];
						tx_pay_q <= {tx_pay_q[39:0], 8'h00};
						tx_acc_q <= csum_add(ctrl_q[RSM_F_SUM], tx_acc_q,
							tx_pay_q[47:40]);
					end
					tx_pos_q <= tx_pos_q + 4'h1;
					if (tx_pos_q == tx_last)
						tx_st_q <= TX_SUM_HI;
				end
				TX_SUM_HI: begin
					tx_data <= RSM_ENC_OFS + {4'h0, tx_acc_q[7:4]};
					tx_st_q <= TX_SUM_LO;
				end
				TX_SUM_LO: begin
					tx_data <= RSM_ENC_OFS + {4'h0, tx_acc_q[3:0]};
					tx_st_q <= TX_CR;
				end
				TX_CR: begin
					tx_data <= RSM_CH_CR;
					tx_st_q <= TX_LF;
				end
				TX_LF: begin
					tx_data <= RSM_CH_LF;
					tx_st_q <= TX_IDLE;
				end
				default: tx_st_q <= TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			started_q <= 1'b0;
		else if (tx_start)
			started_q <= 1'b1;
	end

	// =========================================================
	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_start;
		tx_start;
	endsequence
	sequence s_header;
		tx_valid && tx_data == RSM_CH_DOLLAR && tx_st_q == TX_BODY;
	endsequence

	AST_FIRST_READY: assert property (
		s_start and !started_q |-> pick == S_READY)
		else $error("first sentence is not the ready sentence");
	AST_DOLLAR_START: assert property (
		s_start |=> s_header)
		else $error("sentence did not open with a dollar");
	AST_CLASS_CHAR: assert property (
		tx_st_q == TX_BODY && tx_pos_q == 4'h6 |-> tx_data == RSM_CH_CLASS)
		else $error("class character missing after prefix");
	AST_TO_FROM: assert property (
		tx_st_q != TX_IDLE && tx_type_q == S_NAV
		|-> !(tx_pay_q[3] && tx_pay_q[2]) || tx_pos_q > 4'h8)
		else $error("TO and FROM set together");
	AST_TICK_PERIODIC: assert property (
		tick_q && ctrl_q[RSM_F_PER]
		|=> pend_q[S_NAV] && pend_q[S_COURSE] && pend_q[S_RADIAL])
		else $error("periodic sentences not queued on tick");
	AST_BAD_CSUM: assert property (
		rx_end && rx_hdr_q && rx_pos_q >= RSM_LEN_MIN && rx_cs_bad
		|=> pend_q[S_ERR] && err_code_q == 2'h0)
		else $error("checksum fault not reported as code 0");
	AST_MIC_RANGE: assert property (
		gain_q >= RSM_LVL_MIN && gain_q <= RSM_LVL_MAX
		&& side_q >= RSM_LVL_MIN && side_q <= RSM_LVL_MAX)
		else $error("mic gain or sidetone out of range");
	AST_VOL_REPORT: assert property (
		$changed(vol_q) || $changed(sq_q) |=> pend_q[S_VOL])
		else $error("volume change not reported");
	AST_WHOLE_SENTENCE: assert property (
		tx_st_q != TX_IDLE |=> $stable(tx_type_q))
		else $error("sentence kind changed mid sentence");
	AST_FREQ_REJECT: assert property (
		bus_err_v |=> pend_q[S_ERR] && $stable(freq_q))
		else $error("invalid frequency accepted or not reported");
	AST_END_CRLF: assert property (
		tx_st_q == TX_CR && tx_adv
		|=> tx_valid && tx_data == RSM_CH_CR && tx_st_q == TX_LF)
		else $error("sentence did not end in CR");

endmodule

// File: rsm_host_model.sv
`timescale 1ns/1ns
// file: behavioural host controller on the far side of the serial link
module rsm_host_model (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            tx_ready,
	output logic            rx_valid,
	output logic      [7:0] rx_data
);
	string      done[$];
	string      cur = "";
	logic       slow = 1'b0;
	logic [1:0] cnt = 2'h0;
	initial tx_ready = 1'b1;
	initial rx_valid = 1'b0;
	initial rx_data = 8'h00;
	// =====
	// sink: slow mode takes one char in four so tx_data must stand
	always @(posedge hclk) begin
		cnt <= cnt + 2'h1;
		tx_ready <= !slow || cnt == 2'h3;
		if (hresetn && tx_valid && tx_ready) begin
			cur = $sformatf("%s%c", cur, tx_data);
			if (tx_data == 8'h0A) begin
				done.push_back(cur);
				cur = "";
			end
		end
	end
	// =====
	// source: idle data shows the inverse so stale bytes cannot pass
	task automatic send(input string s);
		foreach (s[i]) begin
			@(posedge hclk);
			rx_valid <= 1'b1;
			rx_data <= s[i];
		end
		@(posedge hclk);
		rx_valid <= 1'b0;
		rx_data <= ~rx_data;
	endtask
endmodule

// File: radio_serial_message_codec_tb_top.sv
`timescale 1ns/1ns
// file: bench of the radio serial message codec
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
	$display("unexpected %0t got %h exp %h", $time, g, e); end end
module radio_serial_message_codec_tb_top import rsm_pkg::*; ;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic        hreadyout, hresp, rx_valid, tx_valid, tx_ready;
	logic [7:0]  rx_data, tx_data;
	int          bad_count = 0, compares = 0, cyc = 0;
	string       s;
	bit          sum_mode = 1'b0;
	always #2 hclk = ~hclk;
	rsm_codec #(.TICK_CYCLES(200)) dut (.hclk, .hresetn, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
		.hreadyout, .hresp, .rx_valid, .rx_data, .tx_valid, .tx_data,
		.tx_ready);
	rsm_host_model host (.hclk, .hresetn, .tx_valid, .tx_data, .tx_ready,
		.rx_valid, .rx_data);
	// =====
	// sentence framing with xor checksum, or additive when sum_mode is set, as two encoded chars
	function automatic string fr(input string id, input string pl);
		string b;
		byte   c;
		b = $sformatf("%s%c%s%s", RSM_SENTENCE_PREFIX, RSM_CH_CLASS, id, pl);
		c = 0;
		foreach (b[i]) c = sum_mode ? byte'(c + b[i]) : c ^ b[i];
		return $sformatf("$%s%c%c", b, RSM_ENC_OFS + c[7:4],
			RSM_ENC_OFS + c[3:0]);
	endfunction
	// single word transfer; a read compares hrdata with d
	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		if (!w) `CHK(hrdata, d)
		`CHK(hresp, 1'b0)
	endtask
	task automatic expect_s(input string id, input string pl);
		string g, e;
		e = {fr(id, pl), "\r\n"};
		while (host.done.size() == 0) @(posedge hclk);
		g = host.done.pop_front();
		`CHK(g.len(), e.len())
		foreach (e[i]) `CHK(g[i], e[i])
	endtask
	task automatic results;
		if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// =====
	// a hang is cut short well beyond the 1300 or so cycles needed
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			results;
		end
	end
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1, RSM_OFS_NAVDEV, 32'h00FE_7F81);
		ahb(1, RSM_OFS_COURSE, 32'h0000_0190);
		ahb(1, RSM_OFS_RADIAL, 32'h0004_00A5);
		expect_s("20", "");
		expect_s("21", "9<64?2");
		expect_s("22", "359");
		expect_s("23", "I1654");
		ahb(1, RSM_OFS_CTRL, 32'h0000_4E00);
		host.slow <= 1'b1;
		ahb(1, RSM_OFS_AUDIO, 32'h0F0B_0F0B);
		expect_s("71", ";?");
		expect_s("72", ";?");
		ahb(1, RSM_OFS_AUDIO, 32'h150B_0F0B);
		ahb(0, RSM_OFS_AUDIO, 32'h0F0B_0F0B);
		host.send({fr("72", "45"), "\r"});
		expect_s("72", "45");
		ahb(0, RSM_OFS_AUDIO, 32'h0504_0F0B);
		host.send({fr("72", "D1"), "\r"});
		expect_s("72", "D1");
		ahb(0, RSM_OFS_AUDIO, 32'h0114_0F0B);
		host.send({fr("24", "71"), "\r"});
		expect_s("71", ";?");
		s = {fr("72", "55"), "\r"};
		s.putc(10, s[10] ^ 8'h01);
		host.send(s);
		expect_s("27", "0");
		ahb(1, RSM_OFS_FREQ, 32'h0076_0099);
		expect_s("27", "2");
		ahb(0, 8'h30, 32'h0);
		ahb(1, RSM_OFS_CSTAT, 32'h0000_0006);
		ahb(1, RSM_OFS_NAVST, 32'h3132_3334);
		expect_s("28", "1234N");
		ahb(1, RSM_OFS_REQ, 32'h0000_01E0);
		expect_s("28", "1234N");
		expect_s("30", "0100R");
		expect_s("35", "F0F0S1");
		expect_s("36", "0100");
		ahb(1, RSM_OFS_REQ, 32'h0000_0001);
		expect_s("20", "");
		ahb(1, RSM_OFS_CTRL, 32'h0000_4E06);
		sum_mode = 1'b1;
		ahb(1, RSM_OFS_REQ, 32'h0000_0041);
		expect_s("20", "");
		expect_s("30", "0100E");
		ahb(0, RSM_OFS_STATUS, 32'h0002_0000);
		results;
	end
endmodule
